// file: src/fram_cmd_pkg.sv
package fram_cmd_pkg;
   localparam logic [7:0]  OP_LATCH_SET    = 8'h06;
   localparam logic [7:0]  OP_LATCH_CLEAR  = 8'h04;
   localparam logic [7:0]  OP_STATUS_READ  = 8'h05;
   localparam logic [7:0]  OP_STATUS_WRITE = 8'h01;
   localparam logic [7:0]  OP_MEM_WRITE    = 8'h02;
   localparam logic [7:0]  OP_MEM_READ     = 8'h03;
   localparam logic [7:0]  OP_SECTOR_WRITE = 8'h42;
   localparam logic [7:0]  OP_SERIAL_WRITE = 8'hC2;
   localparam int          ADDR_W          = 19;
   localparam int          MEM_DEPTH       = 524288;
   localparam logic [18:0] QUARTER_BASE    = 19'h60000;
   localparam logic [18:0] HALF_BASE       = 19'h40000;
   localparam int          BIT_READY       = 0;
   localparam int          BIT_LATCH       = 1;
   localparam int          BIT_GUARD_LOW   = 2;
   localparam int          BIT_GUARD_HIGH  = 3;
   localparam int          BIT_PIN_GATE    = 7;
   localparam logic [7:0]  STATUS_FIXED    = 8'h40;
   localparam logic [2:0]  LAST_BIT        = 3'h7;
   localparam logic [1:0]  ADDR_BYTES      = 2'h3;

   typedef enum logic [2:0] {
      ST_OPCODE   = 3'b000,
      ST_ADDR     = 3'b001,
      ST_WDATA    = 3'b010,
      ST_RDATA    = 3'b011,
      ST_SDATA    = 3'b100,
      ST_STATUS   = 3'b101,
      ST_IGNORE   = 3'b110
   } phase_type;
endpackage : fram_cmd_pkg

// file: src/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int               WIDTH   = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input  wire logic             i_mclk,
   input  wire logic             i_rst_n,
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);
   typedef struct packed {
      logic [WIDTH-1:0] first;
      logic [WIDTH-1:0] second;
   } sync_type;

   sync_type state;
   sync_type next_state;

   always_comb begin
      next_state.first  = i_async;
      next_state.second = state.first;
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         // Idle pin levels, so no false edge follows reset
         state.first  <= RST_VAL;
         state.second <= RST_VAL;
      end else begin
         state <= next_state;
      end
   end

   assign o_sync = state.second;
endmodule : pin_sync
`default_nettype wire

// file: src/spi_fram_protect_rw_engine.sv
// How it works
// - Status bits 0, 4, 5 read zero, bit 6 reads one; writes never change them.
// - Bit 0 reads zero: memory is never busy.
// - Write latch flag at bit 1, cleared at power-up, one means writes allowed.
// - Status write clears latch flag at chip select rising; only the set command sets it.
// - Block guard bits 2 and 3 are retained and start cleared.
// - Guard 01 protects upper quarter, 10 upper half, 11 whole array.
// - Array writes blocked only by clear latch or guarded address, never pin.
// - With pin gate bit clear, protect pin level is ignored.
// - Status write rejected if gate set and pin low, or latch clear.
// - Opcode 05h shifts out the status byte.
// - Opcode 01h plus data updates gate and guard bits; clears latch.
// - Opcode 02h takes three address bytes, low 19 bits used.
// - Write address increments per byte, wraps 7FFFFh to zero, no page limit.
// - Data byte taken MSB first, committed at eighth clock; partial byte dropped.
// - Burst write hitting guarded address stops incrementing, drops later bytes.
// - Chip select rising ends a memory write.
// - Opcode 03h plus address: data driven out, serial input ignored.
// - Read address increments per byte, wraps top to zero.
// - Chip select rising ends read, serial output released.
// - Opcode 06h sets the write latch; 04h clears it.
// - Latch clears at chip select rising after clear or any write command.
// - Unknown opcode ignored; input disregarded, output released until next frame.
// - Opcode, address and data shift most significant bit first.
`timescale 1ns/1ps
`default_nettype none
module spi_fram_protect_rw_engine
   import fram_cmd_pkg::*;
(
   input  wire logic i_mclk,
   input  wire logic i_rst_n,
   input  wire logic i_sck,
   input  wire logic i_cs_n,
   input  wire logic i_si,
   input  wire logic i_wp_n,
   output logic      o_so,
   output logic      o_so_oe_n
);
   typedef struct packed {
      logic             sck_q;
      logic             cs_q;
      logic             sck_mode;
      logic             latch;
      logic             latch_drop;
      logic             guard_low;
      logic             guard_high;
      logic             pin_gate;
      phase_type        phase;
      logic [7:0]       opcode;
      logic [7:0]       shift_in;
      logic [2:0]       bit_cnt;
      logic [1:0]       byte_cnt;
      logic [ADDR_W-1:0] addr;
      logic             stopped;
      logic [7:0]       shift_out;
      logic             so;
      logic             so_oe_n;
   } engine_type;

   engine_type state;
   engine_type next_state;

   logic [7:0] mem [MEM_DEPTH];
   logic [7:0] mem_rdata;
   logic       mem_we;
   logic [ADDR_W-1:0] mem_waddr;
   logic [7:0] mem_wdata;

   logic       sck_s;
   logic       cs_s;
   logic       si_s;
   logic       wp_s;
   logic [7:0] status_byte;
   logic [7:0] byte_in;
   logic       sck_rise;
   logic       sck_fall;
   logic       frame_start;
   logic       frame_end;
   logic       active;
   logic       first_rise_skip;

   pin_sync #(
      .WIDTH   (4),
      .RST_VAL (4'h5)
   ) u_sync (
      .i_mclk  (i_mclk),
      .i_rst_n (i_rst_n),
      .i_async ({i_sck, i_cs_n, i_si, i_wp_n}),
      .o_sync  ({sck_s, cs_s, si_s, wp_s})
   );

   // Array read port, addressed by the registered pointer
   assign mem_rdata = mem[state.addr];

   always_ff @(posedge i_mclk) begin
      if (mem_we) begin
         mem[mem_waddr] <= mem_wdata;
      end
   end

   function automatic logic addr_guarded(input logic [1:0] guard, input logic [ADDR_W-1:0] a);
      logic hit;
      hit = 1'b0;
      case (guard)
         2'b01:   hit = (a >= QUARTER_BASE);
         2'b10:   hit = (a >= HALF_BASE);
         2'b11:   hit = 1'b1;
         default: hit = 1'b0;
      endcase
      return hit;
   endfunction : addr_guarded

   always_comb begin
      status_byte                 = STATUS_FIXED;
      status_byte[BIT_READY]      = 1'b0;
      status_byte[BIT_LATCH]      = state.latch;
      status_byte[BIT_GUARD_LOW]  = state.guard_low;
      status_byte[BIT_GUARD_HIGH] = state.guard_high;
      status_byte[BIT_PIN_GATE]   = state.pin_gate;
   end

   assign sck_rise    = sck_s && !state.sck_q;
   assign sck_fall    = !sck_s && state.sck_q;
   assign frame_start = !cs_s && state.cs_q;
   assign frame_end   = cs_s && !state.cs_q;
   assign active      = !cs_s && !state.cs_q;
   assign byte_in     = {state.shift_in[6:0], si_s};
   // In mode 3 the clock idles high; the first rising edge is a real one anyway
   assign first_rise_skip = 1'b0;

   always_comb begin
      next_state = state;
      mem_we     = 1'b0;
      mem_waddr  = state.addr;
      mem_wdata  = byte_in;
      next_state.sck_q = sck_s;
      next_state.cs_q  = cs_s;

      if (frame_start) begin
         next_state.sck_mode  = sck_s;
         next_state.phase     = ST_OPCODE;
         next_state.bit_cnt   = 3'h0;
         next_state.byte_cnt  = 2'h0;
         next_state.stopped   = 1'b0;
         next_state.latch_drop = 1'b0;
         next_state.so_oe_n   = 1'b1;
      end else if (frame_end) begin
         next_state.so_oe_n = 1'b1;
         next_state.phase   = ST_OPCODE;
         if (state.latch_drop) begin
            next_state.latch = 1'b0;
         end
         next_state.latch_drop = 1'b0;
      end else if (active && sck_rise && !first_rise_skip) begin
         next_state.shift_in = byte_in;
         next_state.bit_cnt  = state.bit_cnt + 3'h1;
         case (state.phase)
            ST_OPCODE: begin
               if (state.bit_cnt == LAST_BIT) begin
                  next_state.opcode = byte_in;
                  if (byte_in == OP_LATCH_SET) begin
                     next_state.latch = 1'b1;
                     next_state.phase = ST_IGNORE;
                  end else if (byte_in == OP_LATCH_CLEAR) begin
                     next_state.latch_drop = 1'b1;
                     next_state.phase      = ST_IGNORE;
                  end else if (byte_in == OP_STATUS_READ) begin
                     next_state.phase = ST_STATUS;
                  end else if (byte_in == OP_STATUS_WRITE) begin
                     next_state.phase      = ST_SDATA;
                     next_state.latch_drop = 1'b1;
                  end else if (byte_in == OP_MEM_WRITE || byte_in == OP_MEM_READ) begin
                     next_state.phase    = ST_ADDR;
                     next_state.byte_cnt = 2'h0;
                     if (byte_in == OP_MEM_WRITE) begin
                        next_state.latch_drop = 1'b1;
                     end
                  end else if (byte_in == OP_SECTOR_WRITE || byte_in == OP_SERIAL_WRITE) begin
                     // Not otherwise handled; latch still drops at frame end
                     next_state.latch_drop = 1'b1;
                     next_state.phase      = ST_IGNORE;
                  end else begin
                     next_state.phase = ST_IGNORE;
                  end
               end
            end
            ST_ADDR: begin
               if (state.bit_cnt == LAST_BIT) begin
                  // Upper eight bits shift out of the 19-bit pointer
                  next_state.addr     = {state.addr[ADDR_W-9:0], byte_in};
                  next_state.byte_cnt = state.byte_cnt + 2'h1;
                  if (state.byte_cnt == ADDR_BYTES - 2'h1) begin
                     next_state.phase = (state.opcode == OP_MEM_READ) ? ST_RDATA : ST_WDATA;
                  end
               end
            end
            ST_WDATA: begin
               if (state.bit_cnt == LAST_BIT && !state.stopped) begin
                  if (state.latch && !addr_guarded({state.guard_high, state.guard_low},
                                                   state.addr)) begin
                     mem_we          = 1'b1;
                     next_state.addr = state.addr + 19'h1;
                  end else begin
                     next_state.stopped = 1'b1;
                  end
               end
            end
            ST_RDATA: begin
               // Serial input not used while data goes out
               if (state.bit_cnt == LAST_BIT) begin
                  next_state.addr = state.addr + 19'h1;
               end
            end
            ST_SDATA: begin
               if (state.bit_cnt == LAST_BIT) begin
                  // Gate ignored when clear; latch must be set
                  // Pin level only matters while the gate bit is set
                  if (state.latch && !(state.pin_gate && !wp_s)) begin
                     next_state.pin_gate   = byte_in[BIT_PIN_GATE];
                     next_state.guard_high = byte_in[BIT_GUARD_HIGH];
                     next_state.guard_low  = byte_in[BIT_GUARD_LOW];
                  end
                  next_state.phase = ST_IGNORE;
               end
            end
            default: begin
               next_state.phase = state.phase;
            end
         endcase
      end else if (active && sck_fall) begin
         if (state.phase == ST_STATUS || state.phase == ST_RDATA) begin
            if (state.bit_cnt == 3'h0) begin
               // Load fresh byte and present its top bit
               if (state.phase == ST_STATUS) begin
                  next_state.so        = status_byte[7];
                  next_state.shift_out = {status_byte[6:0], 1'b0};
               end else begin
                  next_state.so        = mem_rdata[7];
                  next_state.shift_out = {mem_rdata[6:0], 1'b0};
               end
            end else begin
               next_state.so        = state.shift_out[7];
               next_state.shift_out = {state.shift_out[6:0], 1'b0};
            end
            next_state.so_oe_n = 1'b0;
         end
      end
      if (cs_s) begin
         next_state.so_oe_n = 1'b1;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         state            <= '0;
         state.sck_q      <= 1'b0;
         state.cs_q       <= 1'b1;
         state.latch      <= 1'b0;
         state.phase      <= ST_OPCODE;
         state.so_oe_n    <= 1'b1;
      end else begin
         state <= next_state;
      end
   end

   assign o_so      = state.so;
   assign o_so_oe_n = state.so_oe_n;
endmodule : spi_fram_protect_rw_engine
`default_nettype wire

// file: tb/spi_fram_protect_rw_engine_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module spi_fram_protect_rw_engine_assertions
   import fram_cmd_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_sck,
   input wire logic i_cs_n,
   input wire logic i_si,
   input wire logic o_so,
   input wire logic o_so_oe_n
);
   logic       sck_q;
   logic [5:0] rises;
   logic [7:0] op;
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);
   // Pin rises and opcode of the current frame
   always_ff @(posedge i_mclk) begin
      sck_q <= i_sck;
      if (!i_rst_n || i_cs_n) begin
         rises <= 6'h00;
      end else if (i_sck && !sck_q && rises != 6'h3F) begin
         rises <= rises + 6'h01;
         if (rises < 6'h08) op <= {op[6:0], i_si};
      end
   end
   a_release_on_cs: assert property ($rose(i_cs_n) |-> ##[2:6] o_so_oe_n)
      else $error("output kept after frame end");
   a_idle_released: assert property (i_cs_n [*8] |-> o_so_oe_n)
      else $error("output driven while deselected");
   a_drive_in_frame: assert property (!o_so_oe_n |-> !$past(i_cs_n, 6))
      else $error("output driven outside a frame");
   a_hold_to_cs: assert property ($rose(o_so_oe_n) |-> $past(i_cs_n, 2))
      else $error("output released inside a frame");
   a_out_after_fall: assert property ($fell(o_so_oe_n) |-> $past(i_sck, 6) && !$past(i_sck, 2))
      else $error("first bit not after a clock fall");
   a_so_steady: assert property (i_sck [*6] ##1 !o_so_oe_n |-> $stable(o_so))
      else $error("output bit moved while clock high");
   a_first_bit_slot: assert property ($fell(o_so_oe_n) |->
      (rises == 6'h08 && op == OP_STATUS_READ) || (rises == 6'h20 && op == OP_MEM_READ))
      else $error("output starts at wrong bit");
   a_other_quiet: assert property (rises >= 6'h08 && op != OP_STATUS_READ && op != OP_MEM_READ
      |-> o_so_oe_n)
      else $error("output driven for non-read opcode");
   cover property ($fell(o_so_oe_n) && op == OP_STATUS_READ);
   cover property ($fell(o_so_oe_n) && op == OP_MEM_READ);
   cover property (rises == 6'h08 && op == OP_LATCH_SET);
endmodule : spi_fram_protect_rw_engine_assertions
bind spi_fram_protect_rw_engine spi_fram_protect_rw_engine_assertions i_chk (
   .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_sck(i_sck), .i_cs_n(i_cs_n),
   .i_si(i_si), .o_so(o_so), .o_so_oe_n(o_so_oe_n));
`default_nettype wire

// file: tb/spi_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
   input  wire logic i_mclk,
   input  wire logic i_so,
   output var logic  o_sck,
   output var logic  o_cs_n,
   output var logic  o_si
);
   initial begin
      o_sck = 1'b0;
      o_cs_n = 1'b1;
      o_si = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge i_mclk);
   endtask : tick
   task automatic start();
      tick(1);
      o_cs_n <= 1'b0;
      tick(10);
   endtask : start
   // Data line flips on release so stale bits never look valid
   task automatic stop();
      tick(10);
      o_cs_n <= 1'b1;
      o_si <= ~o_si;
      tick(8);
   endtask : stop
   // Mode 0, 21 mclk a bit, n bits from the top
   task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
      rx = 8'h00;
      for (int b = 7; b > 7 - n; b--) begin
         tick(1);
         o_si <= tx[b];
         tick(10);
         o_sck <= 1'b1;
         rx[b] = i_so;
         tick(10);
         o_sck <= 1'b0;
      end
   endtask : xfer
endmodule : spi_master_model
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import fram_cmd_pkg::*;
   logic        mclk = 1'b0;
   logic        rst_n = 1'b0;
   logic        wp_n = 1'b1;
   logic        sck, cs_n, si, so, so_oe_n;
   int          bad_count = 0;
   int          checks_done = 0;
   int          cycles = 0;
   logic [15:0] rd;
   logic [7:0]  exp_mem [4];
   logic [18:0] probe [4] = '{19'h3FFFF, 19'h40000, 19'h5FFFF, 19'h60000};
   always #2 mclk = ~mclk;
   spi_fram_protect_rw_engine i_dut (.i_mclk(mclk), .i_rst_n(rst_n), .i_sck(sck),
      .i_cs_n(cs_n), .i_si(si), .i_wp_n(wp_n), .o_so(so), .o_so_oe_n(so_oe_n));
   spi_master_model i_master (.i_mclk(mclk), .i_so(so), .o_sck(sck), .o_cs_n(cs_n), .o_si(si));
   task automatic give_verdict();
      if (bad_count == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : give_verdict
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic cmd(input logic [7:0] op);
      logic [7:0] r;
      i_master.start();
      i_master.xfer(op, 8, r);
      i_master.stop();
   endtask : cmd
   task automatic mem(input logic [7:0] op, input logic [23:0] a, input logic [15:0] wd,
                      input int n, input int tail);
      logic [7:0] r;
      rd = 16'h0000;
      i_master.start();
      i_master.xfer(op, 8, r);
      for (int k = 2; k >= 0; k--) i_master.xfer(a[8*k+:8], 8, r);
      for (int k = 0; k < n; k++) begin
         i_master.xfer(wd[15-8*k-:8], 8, r);
         rd[15-8*k-:8] = r;
      end
      if (tail > 0) i_master.xfer(8'hFF, tail, r);
      i_master.stop();
   endtask : mem
   task automatic status_rd();
      mem(OP_STATUS_READ, 24'h000000, 16'h0000, 0, 0);
   endtask : status_rd
   task automatic set_status(input logic [7:0] v, input logic latch);
      if (latch) cmd(OP_LATCH_SET);
      mem(OP_STATUS_WRITE, {v, 16'h0000}, 16'h0000, 0, 0);
   endtask : set_status
   task automatic t_latch();
      cmd(OP_LATCH_SET);
      i_master.start();
      i_master.xfer(OP_STATUS_READ, 8, rd[15:8]);
      i_master.xfer(8'h00, 8, rd[7:0]);
      i_master.stop();
      check("latch on", {8'h00, rd[7:0]}, 16'h0042);
      mem(8'hAB, 24'h000000, 16'h0000, 1, 0);
      check("stray out", {15'h0000, so_oe_n}, 16'h0001);
      cmd(OP_LATCH_CLEAR);
      i_master.start();
      i_master.xfer(OP_STATUS_READ, 8, rd[15:8]);
      i_master.xfer(8'h00, 8, rd[7:0]);
      i_master.stop();
      check("latch off", {8'h00, rd[7:0]}, {8'h00, STATUS_FIXED});
   endtask : t_latch
   // Pin level, data, latch, expected status
   task automatic t_status();
      logic [23:0] tbl [5] = '{24'h1FF1CC, 24'h0001CC, 24'h1000CC, 24'h104144, 24'h008148};
      for (int i = 0; i < 5; i++) begin
         @(posedge mclk) wp_n <= tbl[i][20];
         set_status(tbl[i][19:12], tbl[i][8]);
         i_master.start();
         i_master.xfer(OP_STATUS_READ, 8, rd[15:8]);
         i_master.xfer(8'h00, 8, rd[7:0]);
         i_master.stop();
         check("status", {8'h00, rd[7:0]}, {8'h00, tbl[i][7:0]});
      end
   endtask : t_status
   task automatic t_guard();
      for (int g = 0; g < 4; g++) begin
         @(posedge mclk) wp_n <= 1'b1;
         set_status({4'h8, 2'(g), 2'h0}, 1'b1);
         @(posedge mclk) wp_n <= 1'b0;
         for (int p = 0; p < 4; p++) begin
            cmd(OP_LATCH_SET);
            mem(OP_MEM_WRITE, {5'h1F, probe[p]}, {8'hA0 + 8'(g), 8'h00}, 1, 0);
            if (!(g == 3 || (g == 2 && probe[p] >= HALF_BASE) ||
                  (g == 1 && probe[p] >= QUARTER_BASE))) exp_mem[p] = 8'hA0 + 8'(g);
         end
         for (int p = 0; p < 4; p++) begin
            mem(OP_MEM_READ, {5'h00, probe[p]}, 16'hFFFF, 1, 0);
            check("guard", rd, {exp_mem[p], 8'h00});
         end
      end
   endtask : t_guard
   task automatic t_burst();
      @(posedge mclk) wp_n <= 1'b1;
      set_status(8'h00, 1'b1);
      cmd(OP_LATCH_SET);
      mem(OP_MEM_WRITE, 24'h07FFFF, 16'h1122, 2, 0);
      mem(OP_MEM_READ, 24'h07FFFF, 16'hFFFF, 2, 0);
      check("wrap", rd, 16'h1122);
      cmd(OP_LATCH_SET);
      mem(OP_MEM_WRITE, 24'h03FFFF, 16'h5500, 1, 4);
      mem(OP_MEM_READ, 24'h03FFFF, 16'hFFFF, 2, 0);
      check("partial", rd, {8'h55, exp_mem[1]});
      set_status(8'h04, 1'b1);
      cmd(OP_LATCH_SET);
      mem(OP_MEM_WRITE, 24'h05FFFF, 16'h3344, 2, 0);
      mem(OP_MEM_WRITE, 24'h03FFFF, 16'h6600, 1, 0);
      mem(OP_MEM_READ, 24'h05FFFF, 16'hFFFF, 2, 0);
      check("guard stop", rd, {8'h33, exp_mem[3]});
      mem(OP_MEM_READ, 24'h03FFFF, 16'hFFFF, 1, 0);
      check("no latch", rd, 16'h5500);
   endtask : t_burst
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 90000) begin
         bad_count++;
         give_verdict();
      end
   end
   initial begin
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (4) @(posedge mclk);
      t_latch();
      t_status();
      t_guard();
      t_burst();
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
